/* pps_pkg.sv */
// Package with attribute numbers, reset values, ranges and status bits of the parameter set.
package pps_pkg;
    localparam logic [7:0]  ATTR_GOAL        = 8'h01;
    localparam logic [7:0]  ATTR_PRESENT     = 8'h03;
    localparam logic [7:0]  ATTR_OFFSET      = 8'h04;
    localparam logic [7:0]  ATTR_FOLLOW_LIM  = 8'h05;
    localparam logic [7:0]  ATTR_WINDOW      = 8'h06;
    localparam logic [7:0]  ATTR_NUMERATOR   = 8'h10;
    localparam logic [7:0]  ATTR_DENOMINATOR = 8'h11;
    localparam logic [7:0]  ATTR_POS_SPEED   = 8'h12;
    localparam logic [7:0]  ATTR_MAN_SPEED   = 8'h13;
    localparam logic [7:0]  ATTR_RUN_TORQUE  = 8'h14;
    localparam logic [7:0]  ATTR_UPPER       = 8'h16;
    localparam logic [7:0]  ATTR_LOWER       = 8'h17;

    localparam logic [31:0] RST_GOAL         = 32'h0000_0000;
    localparam logic [31:0] RST_OFFSET       = 32'h0000_0000;
    localparam logic [15:0] RST_FOLLOW_LIM   = 16'h0064;
    localparam logic [15:0] RST_WINDOW       = 16'h0005;
    localparam logic [15:0] RST_NUMERATOR    = 16'h0190;
    localparam logic [15:0] RST_DENOMINATOR  = 16'h0190;
    localparam logic [15:0] RST_POS_SPEED    = 16'h0064;
    localparam logic [15:0] RST_MAN_SPEED    = 16'h0032;
    localparam logic [15:0] RST_RUN_TORQUE   = 16'h0064;
    localparam logic [31:0] RST_UPPER        = 32'h0000_6720;
    localparam logic [31:0] RST_LOWER        = 32'h0000_0320;

    localparam logic [15:0] FOLLOW_LIM_MIN   = 16'h0014;
    localparam logic [15:0] FOLLOW_LIM_MAX   = 16'h03e8;
    localparam logic [15:0] WINDOW_MIN       = 16'h0001;
    localparam logic [15:0] WINDOW_BASE_MAX  = 16'h0064;
    localparam logic [15:0] SCALE_MIN        = 16'h0001;
    localparam logic [15:0] SCALE_MAX        = 16'h2710;

    localparam int          STAT_IN_POS      = 0;
    localparam int          STAT_FOLLOW_ERR  = 1;
    localparam int          STAT_BAD_GOAL    = 12;
endpackage : pps_pkg

/* pps_scale.sv */
// Registered ratio scaler that turns a signed value into value * mul / div.
`timescale 1ns/1ns
`default_nettype none
module pps_scale #(
    parameter int WIDTH = 32
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    ce_in,
    input  wire logic signed [WIDTH-1:0] value_in,
    input  wire logic        [15:0]      mul_in,
    input  wire logic        [15:0]      div_in,
    output logic      signed [WIDTH-1:0] value_out
);
    logic signed [WIDTH+16:0] product;
    logic signed [WIDTH+16:0] quotient;
    logic        [15:0]       safe_div;

    assign safe_div = (div_in == 16'h0000) ? 16'h0001 : div_in;
    assign product  = value_in * $signed({1'b0, mul_in});
    assign quotient = product / $signed({1'b0, safe_div});

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            value_out <= '0;
        end else if (ce_in) begin
            value_out <= quotient[WIDTH-1:0];
        end
    end
endmodule : pps_scale
`default_nettype wire

/* pps_param_set.sv */
// Positioning parameter set with attribute port, scaling, window checks and limit selection.
// Overview of operation
// - The goal position is a signed 32-bit attribute in user units that the master reads and writes.
// - Writing the present position moves nothing but re-references the reported position to the written value.
// - The signed offset attribute is added to present position and both goal bounds and subtracted from the goal before it is scaled to counts.
// - The following-error flag rises while running when the lag in increments exceeds the limit, default 100.
// - The in-position flag is set only while goal and present differ by no more than the window, default 5, whose maximum scales with resolution.
// - Counts and user units convert through a 16-bit numerator and denominator, both 400 at reset.
// - The positioning-run speed limit is a 16-bit rpm attribute applied during automatic runs.
// - The manual-run speed limit is a separate 16-bit rpm attribute applied during manual runs.
// - The running torque limit applies only after the start phase; during it the start-up limit applies.
// - Signed upper and lower goal bounds mark goal values outside them as not allowed.
// - The bounds reset to 26400 and 800 and their allowed range scales with denominator over numerator.
// - Status bit 0 shows in position and status bit 1 shows following error.
// - Status bit 12 shows an out-of-bounds or unacceptable goal value.
`timescale 1ns/1ns
`default_nettype none
module pps_param_set #(
    parameter int WIDTH = 32
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    ce_in,
    input  wire logic        [7:0]       attr_num_in,
    input  wire logic                    attr_wr_in,
    input  wire logic                    attr_rd_in,
    input  wire logic        [31:0]      attr_wdata_in,
    output logic             [31:0]      attr_rdata_out,
    output logic                         attr_ack_out,
    output logic                         attr_err_out,
    input  wire logic signed [WIDTH-1:0] measured_count_in,
    input  wire logic                    run_active_in,
    input  wire logic                    manual_run_in,
    input  wire logic                    start_phase_in,
    input  wire logic        [15:0]      startup_torque_limit_in,
    output logic signed [WIDTH-1:0]      goal_count_out,
    output logic                         in_position_out,
    output logic                         following_error_out,
    output logic                         goal_invalid_out,
    output logic             [15:0]      status_word_out,
    output logic             [15:0]      speed_limit_out,
    output logic             [15:0]      torque_limit_out
);
    logic signed [31:0] goal_position;
    logic signed [31:0] position_offset;
    logic signed [31:0] reference_shift;
    logic        [15:0] following_error_limit;
    logic        [15:0] in_position_window;
    logic        [15:0] scale_numerator;
    logic        [15:0] scale_denominator;
    logic        [15:0] positioning_speed_limit;
    logic        [15:0] manual_speed_limit;
    logic        [15:0] running_torque_limit;
    logic signed [31:0] goal_upper_bound;
    logic signed [31:0] goal_lower_bound;

    logic signed [WIDTH-1:0] scaled_measured;
    logic signed [WIDTH-1:0] scaled_goal;
    logic signed [31:0]      present_position;
    logic signed [31:0]      goal_internal;
    logic signed [32:0]      pos_diff;
    logic        [32:0]      pos_dist;
    logic signed [WIDTH:0]   lag_diff;
    logic        [WIDTH:0]   lag_dist;
    logic        [31:0]      window_max;
    logic        [31:0]      bound_span;
    logic signed [32:0]      upper_eff;
    logic signed [32:0]      lower_eff;
    logic                    next_in_position;
    logic                    next_following_error;
    logic                    next_goal_invalid;
    logic                    wr_goal;
    logic                    wr_present;
    logic                    wr_offset;
    logic                    wr_follow;
    logic                    wr_window;
    logic                    wr_num;
    logic                    wr_den;
    logic                    wr_pos_speed;
    logic                    wr_man_speed;
    logic                    wr_torque;
    logic                    wr_upper;
    logic                    wr_lower;
    logic                    known_attr;
    logic                    value_ok;
    logic                    wr_take;
    logic        [31:0]      next_rdata;

    // Measured counts to user units, and goal in user units back to counts.
    pps_scale #(.WIDTH(WIDTH)) u_scale_present (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .ce_in      (ce_in),
        .value_in   (measured_count_in),
        .mul_in     (scale_denominator),
        .div_in     (scale_numerator),
        .value_out  (scaled_measured)
    );
    pps_scale #(.WIDTH(WIDTH)) u_scale_goal (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .ce_in      (ce_in),
        .value_in   (goal_internal),
        .mul_in     (scale_numerator),
        .div_in     (scale_denominator),
        .value_out  (scaled_goal)
    );

    assign present_position = scaled_measured + reference_shift + position_offset;
    assign goal_internal    = goal_position - position_offset - reference_shift;
    assign upper_eff        = 33'(goal_upper_bound) + 33'(position_offset);
    assign lower_eff        = 33'(goal_lower_bound) + 33'(position_offset);

    assign pos_diff   = 33'(goal_position) - 33'(present_position);
    assign pos_dist   = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
    assign lag_diff   = (WIDTH+1)'(scaled_goal) - (WIDTH+1)'(measured_count_in);
    assign lag_dist   = lag_diff[WIDTH] ? (WIDTH+1)'(-lag_diff) : (WIDTH+1)'(lag_diff);
    localparam logic [15:0] WINDOW_MAX_NUM = pps_pkg::WINDOW_BASE_MAX;
    localparam logic [31:0] RANGE_SPAN     = pps_pkg::RST_UPPER;

    assign window_max = (32'(WINDOW_MAX_NUM) * 32'(scale_denominator))
                        / 32'(scale_numerator == 16'h0000 ? 16'h0001 : scale_numerator);
    assign bound_span = (32'(RANGE_SPAN) * 32'(scale_denominator))
                        / 32'(scale_numerator == 16'h0000 ? 16'h0001 : scale_numerator);

    assign next_in_position     = (pos_dist <= 33'(in_position_window));
    assign next_following_error = run_active_in
                                  && (lag_dist > (WIDTH+1)'(following_error_limit));
    assign next_goal_invalid    = (33'(goal_position) > upper_eff)
                                  || (33'(goal_position) < lower_eff);

    assign wr_goal      = attr_wr_in && (attr_num_in == pps_pkg::ATTR_GOAL);
    assign wr_present   = attr_wr_in && (attr_num_in == pps_pkg::ATTR_PRESENT);
    assign wr_offset    = attr_wr_in && (attr_num_in == pps_pkg::ATTR_OFFSET);
    assign wr_follow    = attr_wr_in && (attr_num_in == pps_pkg::ATTR_FOLLOW_LIM);
    assign wr_window    = attr_wr_in && (attr_num_in == pps_pkg::ATTR_WINDOW);
    assign wr_num       = attr_wr_in && (attr_num_in == pps_pkg::ATTR_NUMERATOR);
    assign wr_den       = attr_wr_in && (attr_num_in == pps_pkg::ATTR_DENOMINATOR);
    assign wr_pos_speed = attr_wr_in && (attr_num_in == pps_pkg::ATTR_POS_SPEED);
    assign wr_man_speed = attr_wr_in && (attr_num_in == pps_pkg::ATTR_MAN_SPEED);
    assign wr_torque    = attr_wr_in && (attr_num_in == pps_pkg::ATTR_RUN_TORQUE);
    assign wr_upper     = attr_wr_in && (attr_num_in == pps_pkg::ATTR_UPPER);
    assign wr_lower     = attr_wr_in && (attr_num_in == pps_pkg::ATTR_LOWER);

    assign known_attr = (attr_num_in == pps_pkg::ATTR_GOAL)
                        || (attr_num_in == pps_pkg::ATTR_PRESENT)
                        || (attr_num_in == pps_pkg::ATTR_OFFSET)
                        || (attr_num_in == pps_pkg::ATTR_FOLLOW_LIM)
                        || (attr_num_in == pps_pkg::ATTR_WINDOW)
                        || (attr_num_in == pps_pkg::ATTR_NUMERATOR)
                        || (attr_num_in == pps_pkg::ATTR_DENOMINATOR)
                        || (attr_num_in == pps_pkg::ATTR_POS_SPEED)
                        || (attr_num_in == pps_pkg::ATTR_MAN_SPEED)
                        || (attr_num_in == pps_pkg::ATTR_RUN_TORQUE)
                        || (attr_num_in == pps_pkg::ATTR_UPPER)
                        || (attr_num_in == pps_pkg::ATTR_LOWER);

    // Range checks on written values; 16-bit attributes need zero upper bits.
    assign value_ok =
        (wr_follow && (attr_wdata_in[31:16] == 16'h0000)
            && (attr_wdata_in[15:0] >= pps_pkg::FOLLOW_LIM_MIN)
            && (attr_wdata_in[15:0] <= pps_pkg::FOLLOW_LIM_MAX))
        || (wr_window && (attr_wdata_in[31:16] == 16'h0000)
            && (attr_wdata_in[15:0] >= pps_pkg::WINDOW_MIN)
            && (attr_wdata_in <= window_max))
        || ((wr_num || wr_den) && (attr_wdata_in[31:16] == 16'h0000)
            && (attr_wdata_in[15:0] >= pps_pkg::SCALE_MIN)
            && (attr_wdata_in[15:0] <= pps_pkg::SCALE_MAX))
        || ((wr_pos_speed || wr_man_speed || wr_torque)
            && (attr_wdata_in[31:16] == 16'h0000))
        || ((wr_upper || wr_lower) && ($signed(attr_wdata_in) >= 0)
            && (attr_wdata_in <= bound_span))
        || wr_goal || wr_present || wr_offset;

    assign wr_take = ce_in && value_ok;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (attr_num_in)
            pps_pkg::ATTR_GOAL:        next_rdata = goal_position;
            pps_pkg::ATTR_PRESENT:     next_rdata = present_position;
            pps_pkg::ATTR_OFFSET:      next_rdata = position_offset;
            pps_pkg::ATTR_FOLLOW_LIM:  next_rdata = {16'h0000, following_error_limit};
            pps_pkg::ATTR_WINDOW:      next_rdata = {16'h0000, in_position_window};
            pps_pkg::ATTR_NUMERATOR:   next_rdata = {16'h0000, scale_numerator};
            pps_pkg::ATTR_DENOMINATOR: next_rdata = {16'h0000, scale_denominator};
            pps_pkg::ATTR_POS_SPEED:   next_rdata = {16'h0000, positioning_speed_limit};
            pps_pkg::ATTR_MAN_SPEED:   next_rdata = {16'h0000, manual_speed_limit};
            pps_pkg::ATTR_RUN_TORQUE:  next_rdata = {16'h0000, running_torque_limit};
            pps_pkg::ATTR_UPPER:       next_rdata = goal_upper_bound;
            pps_pkg::ATTR_LOWER:       next_rdata = goal_lower_bound;
            default:                   next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            goal_position           <= pps_pkg::RST_GOAL;
            position_offset         <= pps_pkg::RST_OFFSET;
            reference_shift         <= 32'h0000_0000;
            following_error_limit   <= pps_pkg::RST_FOLLOW_LIM;
            in_position_window      <= pps_pkg::RST_WINDOW;
            scale_numerator         <= pps_pkg::RST_NUMERATOR;
            scale_denominator       <= pps_pkg::RST_DENOMINATOR;
            positioning_speed_limit <= pps_pkg::RST_POS_SPEED;
            manual_speed_limit      <= pps_pkg::RST_MAN_SPEED;
            running_torque_limit    <= pps_pkg::RST_RUN_TORQUE;
            goal_upper_bound        <= pps_pkg::RST_UPPER;
            goal_lower_bound        <= pps_pkg::RST_LOWER;
        end else if (wr_take) begin
            if (wr_goal)      goal_position           <= attr_wdata_in;
            if (wr_present)   reference_shift         <= attr_wdata_in - scaled_measured
                                                         - position_offset;
            if (wr_offset)    position_offset         <= attr_wdata_in;
            if (wr_follow)    following_error_limit   <= attr_wdata_in[15:0];
            if (wr_window)    in_position_window      <= attr_wdata_in[15:0];
            if (wr_num)       scale_numerator         <= attr_wdata_in[15:0];
            if (wr_den)       scale_denominator       <= attr_wdata_in[15:0];
            if (wr_pos_speed) positioning_speed_limit <= attr_wdata_in[15:0];
            if (wr_man_speed) manual_speed_limit      <= attr_wdata_in[15:0];
            if (wr_torque)    running_torque_limit    <= attr_wdata_in[15:0];
            if (wr_upper)     goal_upper_bound        <= attr_wdata_in;
            if (wr_lower)     goal_lower_bound        <= attr_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            attr_rdata_out <= 32'h0000_0000;
            attr_ack_out   <= 1'b0;
            attr_err_out   <= 1'b0;
        end else if (ce_in) begin
            attr_ack_out   <= attr_wr_in || attr_rd_in;
            attr_err_out   <= (attr_wr_in && !value_ok) || (attr_rd_in && !known_attr);
            attr_rdata_out <= attr_rd_in ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            goal_count_out      <= '0;
            in_position_out     <= 1'b0;
            following_error_out <= 1'b0;
            goal_invalid_out    <= 1'b0;
            status_word_out     <= 16'h0000;
            speed_limit_out     <= pps_pkg::RST_POS_SPEED;
            torque_limit_out    <= 16'h0000;
        end else if (ce_in) begin
            goal_count_out      <= next_goal_invalid ? goal_count_out : scaled_goal;
            in_position_out     <= next_in_position;
            following_error_out <= next_following_error;
            goal_invalid_out    <= next_goal_invalid;
            status_word_out     <= 16'h0000;
            status_word_out[pps_pkg::STAT_IN_POS]     <= next_in_position;
            status_word_out[pps_pkg::STAT_FOLLOW_ERR] <= next_following_error;
            status_word_out[pps_pkg::STAT_BAD_GOAL]   <= next_goal_invalid;
            speed_limit_out  <= manual_run_in ? manual_speed_limit
                                              : positioning_speed_limit;
            torque_limit_out <= start_phase_in ? startup_torque_limit_in
                                               : running_torque_limit;
        end
    end

    sequence s_goal_write;
        ce_in && wr_goal;
    endsequence
    sequence s_goal_read;
        ce_in && attr_rd_in && (attr_num_in == pps_pkg::ATTR_GOAL);
    endsequence

    property p_goal_readback;
        @(posedge ref_clk_in) disable iff (reset_in)
        s_goal_write ##1 !wr_goal ##1 s_goal_read
            |=> (attr_rdata_out == $past(attr_wdata_in, 3));
    endproperty
    a_goal_readback: assert property (p_goal_readback)
        else $error("Goal read back differs from the value written.");

    property p_reference;
        @(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && wr_present) ##1 (ce_in && $stable(scaled_measured))
            |-> (present_position == $past(attr_wdata_in));
    endproperty
    a_reference: assert property (p_reference)
        else $error("Present position not re-referenced to the written value.");

    property p_follow;
        @(posedge ref_clk_in) disable iff (reset_in)
        ce_in |=> (following_error_out == ($past(run_active_in)
                   && ($past(lag_dist) > (WIDTH+1)'($past(following_error_limit)))));
    endproperty
    a_follow: assert property (p_follow)
        else $error("Following error flag wrong for lag and limit.");

    property p_in_position;
        @(posedge ref_clk_in) disable iff (reset_in)
        ce_in |=> (in_position_out == ($past(pos_dist) <= 33'($past(in_position_window))));
    endproperty
    a_in_position: assert property (p_in_position)
        else $error("In-position flag wrong for distance and window.");

    property p_bad_scale;
        @(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && wr_num && (attr_wdata_in == 32'h0000_0000))
            |=> $stable(scale_numerator) && attr_err_out;
    endproperty
    a_bad_scale: assert property (p_bad_scale)
        else $error("Zero numerator was accepted.");

    property p_speed;
        @(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && !manual_run_in) |=> (speed_limit_out == $past(positioning_speed_limit));
    endproperty
    a_speed: assert property (p_speed)
        else $error("Positioning speed limit not applied.");

    property p_manual_speed;
        @(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && manual_run_in) |=> (speed_limit_out == $past(manual_speed_limit));
    endproperty
    a_manual_speed: assert property (p_manual_speed)
        else $error("Manual speed limit not applied.");

    property p_torque;
        @(posedge ref_clk_in) disable iff (reset_in)
        ce_in |=> (torque_limit_out == ($past(start_phase_in) ? $past(startup_torque_limit_in)
                                                              : $past(running_torque_limit)));
    endproperty
    a_torque: assert property (p_torque)
        else $error("Torque limit source does not match the start phase.");

    property p_status;
        @(posedge ref_clk_in) disable iff (reset_in)
        ##1 (status_word_out[pps_pkg::STAT_IN_POS] == in_position_out)
            && (status_word_out[pps_pkg::STAT_FOLLOW_ERR] == following_error_out)
            && (status_word_out[pps_pkg::STAT_BAD_GOAL] == goal_invalid_out);
    endproperty
    a_status: assert property (p_status)
        else $error("Status word bits disagree with the flags.");

    property p_bounds;
        @(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && (33'(goal_position) > upper_eff)) |=> goal_invalid_out;
    endproperty
    a_bounds: assert property (p_bounds)
        else $error("Goal above the upper bound not flagged.");
endmodule : pps_param_set
`default_nettype wire

/* pps_master_model.sv */
// Fieldbus master model that issues attribute requests.
`timescale 1ns/1ns
`default_nettype none
module pps_master_model (
    input  wire logic        clk_in,
    output logic             wr_out,
    output logic             rd_out,
    output logic [7:0]       num_out,
    output logic [31:0]      data_out
);
    initial begin
        {wr_out, rd_out, num_out, data_out} = '0;
    end
    task automatic access(input logic wr, input logic [7:0] n, input logic [31:0] d);
        @(posedge clk_in);
        #5;
        {wr_out, rd_out, num_out, data_out} = {wr, !wr, n, d};
        @(posedge clk_in);
        #5;
        {wr_out, rd_out, data_out} = {2'b00, ~d};
    endtask : access
endmodule : pps_master_model
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the positioning parameter set.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic ref_clk_in, reset_in, ce_in, attr_wr_in, attr_rd_in, attr_ack_out, attr_err_out;
    logic run_active_in, manual_run_in, start_phase_in, in_position_out, following_error_out;
    logic               goal_invalid_out;
    logic        [7:0]  attr_num_in;
    logic        [31:0] attr_wdata_in, attr_rdata_out, g;
    logic signed [31:0] measured_count_in, goal_count_out;
    logic        [15:0] startup_torque_limit_in, status_word_out, speed_limit_out, torque_limit_out;
    logic        [33:0] exp_q[$];
    logic        [33:0] e;
    logic        [7:0]  an[11] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
        8'h16, 8'h17};
    logic        [31:0] av[11] = '{0, 0, 32'h64, 32'h5, 32'h190, 32'h190, 32'h64, 32'h32, 32'h64,
        32'h6720, 32'h320};
    int                 fails = 0;
    int                 tests_run = 0;
    pps_param_set u_dut (.ref_clk_in, .reset_in, .ce_in, .attr_num_in, .attr_wr_in, .attr_rd_in,
        .attr_wdata_in, .attr_rdata_out, .attr_ack_out, .attr_err_out, .measured_count_in,
        .run_active_in, .manual_run_in, .start_phase_in, .startup_torque_limit_in, .goal_count_out,
        .in_position_out, .following_error_out, .goal_invalid_out, .status_word_out,
        .speed_limit_out, .torque_limit_out);
    pps_master_model u_mst (.clk_in(ref_clk_in), .wr_out(attr_wr_in), .rd_out(attr_rd_in),
        .num_out(attr_num_in), .data_out(attr_wdata_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [7:0] n, input logic [31:0] d,
        input logic [32:0] r);
        exp_q.push_back({!wr, r});
        u_mst.access(wr, n, d);
    endtask : acc
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        ref_clk_in = 0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    always @(negedge ref_clk_in) if (attr_ack_out === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
        chk({31'h0, attr_err_out}, {31'h0, e[32]});
        if (e[33]) chk(attr_rdata_out, e[31:0]);
    end
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(16));
        {reset_in, ce_in, run_active_in, manual_run_in, start_phase_in} = 5'b11000;
        measured_count_in = 0;
        startup_torque_limit_in = 16'($urandom);
        repeat (16) @(posedge ref_clk_in);
        #5 reset_in = 0;
        foreach (an[i]) acc(0, an[i], 0, {1'b0, av[i]});
        acc(1, 8'h05, 19, 33'h100000000);
        acc(1, 8'h11, 150, 0);
        acc(1, 8'h06, 38, 33'h100000000);
        acc(1, 8'h06, 37, 0);
        acc(1, 8'h16, 9901, 33'h100000000);
        acc(1, 8'h11, 400, 0);
        acc(1, 8'h10, 0, 33'h100000000);
        acc(1, 8'h06, 5, 0);
        acc(0, 8'h2a, 0, 33'h100000000);
        g = 800 + $urandom % 25601;
        acc(1, 8'h01, 26401, 0);
        repeat (3) @(posedge ref_clk_in);
        #5;
        chk({16'h0, status_word_out}, 32'h1000);
        chk({29'h0, in_position_out, following_error_out, goal_invalid_out}, 32'h1);
        acc(1, 8'h01, g, 0);
        acc(0, 8'h01, 0, {1'b0, g});
        acc(1, 8'h03, g, 0);
        acc(0, 8'h03, 0, {1'b0, g});
        repeat (3) @(posedge ref_clk_in);
        #5;
        chk({16'h0, status_word_out}, 32'h1);
        chk({29'h0, in_position_out, following_error_out, goal_invalid_out}, 32'h4);
        acc(1, 8'h04, 100, 0);
        acc(0, 8'h03, 0, {1'b0, g + 100});
        chk(goal_count_out, (g < 900) ? 32'h0 : 32'hffff_ff9c);
        acc(1, 8'h04, 0, 0);
        {run_active_in, manual_run_in, start_phase_in} = 3'b111;
        measured_count_in = 32'sd101;
        repeat (3) @(posedge ref_clk_in);
        #5;
        chk({16'h0, status_word_out}, 32'h2);
        chk({29'h0, in_position_out, following_error_out, goal_invalid_out}, 32'h2);
        chk({16'h0, speed_limit_out}, 32'h32);
        chk({16'h0, torque_limit_out}, {16'h0, startup_torque_limit_in});
        {manual_run_in, start_phase_in, measured_count_in} = {2'b00, 32'sd100};
        repeat (3) @(posedge ref_clk_in);
        #5;
        chk({16'h0, status_word_out}, 32'h0);
        chk({speed_limit_out, torque_limit_out}, 32'h00640064);
        for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge ref_clk_in);
        if (exp_q.size() > 0) fails++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
